// File: cpfs_pkg.sv
package cpfs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NPINS = 4;
  localparam int NLEDS = 3;
  localparam int CNT_W = 20;

  typedef logic [3:0] cpfs_func_t;
  typedef logic [CNT_W-1:0] cpfs_cnt_t;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin function codes held in the configuration memory
  localparam cpfs_func_t FN_TRISTATE = 4'h0;
  localparam cpfs_func_t FN_RS485_EN = 4'h1;
  localparam cpfs_func_t FN_DRIVE1 = 4'h2;
  localparam cpfs_func_t FN_DRIVE0 = 4'h3;
  localparam cpfs_func_t FN_POWER_EN = 4'h4;
  localparam cpfs_func_t FN_TX_LED = 4'h5;
  localparam cpfs_func_t FN_RX_LED = 4'h6;
  localparam cpfs_func_t FN_BOTH_LED = 4'h7;
  localparam cpfs_func_t FN_SLEEP = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses) and field layout
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CFG_W = 17;
  localparam int CFG_CANCEL_BIT = 16;
  localparam logic [CFG_W-1:0] CFG_RESET = 17'h00000;
  localparam int ST_OUT_LSB = 0;
  localparam int ST_OE_LSB = 4;
  localparam int ST_IN_LSB = 8;
  localparam int ST_LED_LSB = 12;
  localparam int ST_USB_LSB = 16;

  // led source index
  localparam int LED_TX = 0;
  localparam int LED_RX = 1;
  localparam int LED_BOTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS = 40;
  localparam int LED_ON_US = 20000;
  localparam int LED_OFF_US = 20000;
  localparam int LED_ON_CYC = (LED_ON_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int LED_OFF_CYC = (LED_OFF_US * 1000 + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic configured;
    logic suspend;
    logic serial_tx;
    logic tx_act;
    logic rx_act;
    logic charger_dcp;
  } cpfs_usb_s;

  typedef enum logic [2:0] {
    LED_IDLE = 3'b001,
    LED_ON = 3'b010,
    LED_GAP = 3'b100
  } cpfs_led_e;

endpackage : cpfs_pkg

// File: cpfs_top.sv
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module cpfs_top #(
  parameter cpfs_pkg::cpfs_cnt_t LED_ON_CYC =
    cpfs_pkg::CNT_W'(cpfs_pkg::LED_ON_CYC),
  parameter cpfs_pkg::cpfs_cnt_t LED_OFF_CYC =
    cpfs_pkg::CNT_W'(cpfs_pkg::LED_OFF_CYC)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire cpfs_pkg::cpfs_usb_s usb_i,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, dropped the next cycle

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [cpfs_pkg::CFG_W-1:0] cfg_reg;
  logic [cpfs_pkg::CFG_W-1:0] cfg_next;
  logic [3:0] out_reg;
  logic [3:0] oe_reg;
  logic [3:0] out_next;
  logic [3:0] oe_next;
  logic [2:0] led_low;
  logic [2:0] led_idle;
  logic [3:0] pin_func [4];
  logic [31:0] status_w;
  logic [31:0] rd_data;
  logic cancel_dcp;
  logic sleep_high;
  logic pwr_low;

  wire req = wb_cyc_i & wb_stb_i;
  wire req_new = req & ~ack_reg;
  wire hit_cfg = wb_adr_i == cpfs_pkg::ADDR_CFG;
  wire hit_stat = wb_adr_i == cpfs_pkg::ADDR_STAT;
  wire cfg_wr = ack_reg & req & wb_we_i & hit_cfg;

  // unmapped addresses are acked and read as zero
  assign rd_data = hit_cfg ? {15'h0000, cfg_reg} :
                   hit_stat ? status_w : 32'h00000000;

  assign cfg_next[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : cfg_reg[7:0];
  assign cfg_next[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : cfg_reg[15:8];
  assign cfg_next[16] = wb_sel_i[2] ? wb_dat_i[16] : cfg_reg[16];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req_new;
      if (req_new) begin
        dat_reg <= rd_data;
      end
    end
  end

  // stands in for the nonvolatile configuration memory
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= cpfs_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= cfg_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  assign status_w = {10'h000,
    usb_i, 1'b0, led_low, pin_in, oe_reg, out_reg};

  ////////////////////////////////////////////////////////////////////////////
  // activity led pulse generators: low for the on time, then a gap, so
  // steady traffic shows as blinking rather than a solid light

  wire [2:0] led_act = {usb_i.tx_act | usb_i.rx_act,
                        usb_i.rx_act, usb_i.tx_act};

  for (genvar s = 0; s < cpfs_pkg::NLEDS; s++) begin : g_led
    cpfs_pkg::cpfs_led_e st_reg;
    cpfs_pkg::cpfs_led_e st_next;
    cpfs_pkg::cpfs_cnt_t cnt_reg;
    cpfs_pkg::cpfs_cnt_t cnt_next;
    wire cnt_zero = cnt_reg == '0;

    always_comb begin
      st_next = st_reg;
      cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
      unique case (st_reg)
        cpfs_pkg::LED_IDLE: begin
          if (led_act[s]) begin
            st_next = cpfs_pkg::LED_ON;
            cnt_next = LED_ON_CYC - 1'b1;
          end
        end
        cpfs_pkg::LED_ON: begin
          if (cnt_zero) begin
            st_next = cpfs_pkg::LED_GAP;
            cnt_next = LED_OFF_CYC - 1'b1;
          end
        end
        cpfs_pkg::LED_GAP: begin
          if (cnt_zero) begin
            st_next = cpfs_pkg::LED_IDLE;
          end
        end
        default: begin
          st_next = cpfs_pkg::LED_IDLE;
        end
      endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        st_reg <= cpfs_pkg::LED_IDLE;
        cnt_reg <= '0;
      end else begin
        st_reg <= st_next;
        cnt_reg <= cnt_next;
      end
    end

    assign led_low[s] = st_reg == cpfs_pkg::LED_ON;
    assign led_idle[s] = st_reg == cpfs_pkg::LED_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared indications

  assign cancel_dcp = cfg_reg[cpfs_pkg::CFG_CANCEL_BIT] & usb_i.charger_dcp;
  assign sleep_high = ~usb_i.suspend | cancel_dcp;
  assign pwr_low = usb_i.configured & ~usb_i.suspend;

  // levels come in as arguments: a continuous assignment only wakes on
  // its operands, so levels read straight from the module would go stale
  // returns {oe, out}; open-drain functions only ever drive a zero
  function automatic logic [1:0] pin_sel(input logic [3:0] fn,
    input logic tx_en, input logic pwr, input logic [2:0] led,
    input logic slp);
    unique case (fn)
      cpfs_pkg::FN_RS485_EN: pin_sel = {1'b1, tx_en};
      cpfs_pkg::FN_DRIVE1: pin_sel = 2'b11;
      cpfs_pkg::FN_DRIVE0: pin_sel = 2'b10;
      cpfs_pkg::FN_POWER_EN: pin_sel = {pwr, 1'b0};
      cpfs_pkg::FN_TX_LED:
        pin_sel = {led[cpfs_pkg::LED_TX], 1'b0};
      cpfs_pkg::FN_RX_LED:
        pin_sel = {led[cpfs_pkg::LED_RX], 1'b0};
      cpfs_pkg::FN_BOTH_LED:
        pin_sel = {led[cpfs_pkg::LED_BOTH], 1'b0};
      cpfs_pkg::FN_SLEEP: pin_sel = {1'b1, slp};
      // tristate, and codes of functions not built here, leave pin floating
      default: pin_sel = 2'b00;
    endcase
  endfunction : pin_sel

  ////////////////////////////////////////////////////////////////////////////
  // per-pin selection

  for (genvar i = 0; i < cpfs_pkg::NPINS; i++) begin : g_pin
    wire [1:0] sel_w;
    assign pin_func[i] = cfg_reg[i*4 +: 4];
    assign sel_w = pin_sel(pin_func[i], usb_i.serial_tx, pwr_low,
      led_low, sleep_high);
    assign oe_next[i] = sel_w[1];
    assign out_next[i] = sel_w[0];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  a_wb_ack_next: assert property (s_wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");

  a_cfg_write_takes: assert property (
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && hit_cfg &&
    wb_sel_i == 4'hf |=> cfg_reg == $past(wb_dat_i[16:0]))
    else $error("configuration write lost");

  a_cfg_keep_bit: assert property (
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && hit_cfg &&
    !wb_sel_i[2] |=> cfg_reg[cpfs_pkg::CFG_CANCEL_BIT] ==
    $past(cfg_reg[cpfs_pkg::CFG_CANCEL_BIT]))
    else $error("cancel bit written without its byte enable");

  for (genvar i = 0; i < cpfs_pkg::NPINS; i++) begin : g_chk
    a_tristate_float: assert property (
      pin_func[i] == cpfs_pkg::FN_TRISTATE |=> !pin_oe[i])
      else $error("tristate pin driven");

    a_drive_levels: assert property (
      pin_func[i] == cpfs_pkg::FN_DRIVE1 ##1
      pin_func[i] == cpfs_pkg::FN_DRIVE1 |-> pin_oe[i] && pin_out[i])
      else $error("constant high not driven");

    a_rs485_follow: assert property (
      pin_func[i] == cpfs_pkg::FN_RS485_EN |=>
      pin_oe[i] && pin_out[i] == $past(usb_i.serial_tx))
      else $error("rs485 enable wrong");

    a_power_drain: assert property (
      pin_func[i] == cpfs_pkg::FN_POWER_EN |=> !pin_out[i] &&
      pin_oe[i] == $past(usb_i.configured && !usb_i.suspend))
      else $error("power enable wrong");

    a_tx_led_drain: assert property (
      pin_func[i] == cpfs_pkg::FN_TX_LED |=>
      !pin_out[i] && pin_oe[i] == $past(led_low[cpfs_pkg::LED_TX]))
      else $error("transmit led wrong");

    a_sleep_level: assert property (
      pin_func[i] == cpfs_pkg::FN_SLEEP |=> pin_oe[i] &&
      pin_out[i] == $past(!usb_i.suspend ||
      (cfg_reg[cpfs_pkg::CFG_CANCEL_BIT] && usb_i.charger_dcp)))
      else $error("sleep indicator wrong");

    a_drive_low: assert property (
      pin_func[i] == cpfs_pkg::FN_DRIVE0 |=> pin_oe[i] && !pin_out[i])
      else $error("constant low not driven");

    a_rx_led_drain: assert property (
      pin_func[i] == cpfs_pkg::FN_RX_LED |=>
      !pin_out[i] && pin_oe[i] == $past(led_low[cpfs_pkg::LED_RX]))
      else $error("receive led wrong");

    a_both_drain: assert property (
      pin_func[i] == cpfs_pkg::FN_BOTH_LED |=>
      !pin_out[i] && pin_oe[i] == $past(led_low[cpfs_pkg::LED_BOTH]))
      else $error("combined led wrong");

    a_spare_float: assert property (
      pin_func[i] > cpfs_pkg::FN_SLEEP |=> !pin_oe[i])
      else $error("unused code drives pin");
  end

  sequence s_led_start(int s);
    !led_low[s] && led_idle[s] && led_act[s];
  endsequence

  a_rx_led_pulse: assert property (
    s_led_start(cpfs_pkg::LED_RX) |=> led_low[cpfs_pkg::LED_RX] [*2])
    else $error("receive led pulse too short");

  a_both_pulse: assert property (
    s_led_start(cpfs_pkg::LED_BOTH) |=> led_low[cpfs_pkg::LED_BOTH])
    else $error("combined led did not start");

  for (genvar s = 0; s < cpfs_pkg::NLEDS; s++) begin : g_led_chk
    a_led_gap_kept: assert property (
      led_low[s] ##1 !led_low[s] |=> !led_low[s])
      else $error("led pulse restarted without a gap");
  end

endmodule : cpfs_top

`default_nettype wire

// File: cpfs_board.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// board side: a resistor pulls every pin up, so released pins read high;
// the open-drain functions depend on it to reach their high level
module cpfs_board (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | ~pin_oe;
endmodule : cpfs_board

`default_nettype wire

// File: cpfs_tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, a) begin samples_checked++; \
  if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end

module tb;
  logic clock, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i, pin_in, pin_out, pin_oe;
  cpfs_pkg::cpfs_usb_s usb;
  int num_errors, samples_checked;
  // short led counts keep the run brief
  localparam int ON = 4;
  localparam int OFF = 4;

  cpfs_top #(.LED_ON_CYC(20'(ON)), .LED_OFF_CYC(20'(OFF))) dut (
    .clock(clock), .rst_n(rst_n), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .usb_i(usb), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  cpfs_board board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic tk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tk

  // classic cycle; the wait is bounded so a silent slave ends the run
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20) begin
      num_errors++;
      wrap_up();
    end
  endtask : wb

  task automatic us(input logic [5:0] v);
    @(posedge clock);
    usb <= v;
    tk(2);
  endtask : us

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0);
    `CHK("cfg", 32'h0, rd)
    `CHK("pins", 8'h00, {pin_out, pin_oe})
    wb(1'b1, 8'h00, 32'h1032);
    wb(1'b1, 8'h04, 32'hffffffff);
    wb(1'b0, 8'h00, 32'h0);
    `CHK("cfg", 32'h1032, rd)
    wb(1'b0, 8'h08, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    tk(3);
    `CHK("pins", 8'h1b, {pin_out, pin_oe})
    `CHK("float", 1'b1, pin_in[2])
    us(6'b001000);
    `CHK("pins", 8'h9b, {pin_out, pin_oe})
    $display("test regs done");
  endtask : t_regs

  task automatic t_power;
    us(6'b000000);
    wb(1'b1, 8'h00, 32'hf084);
    tk(3);
    `CHK("pins", 8'h22, {pin_out, pin_oe})
    `CHK("pwr", 1'b1, pin_in[0])
    us(6'b100000);
    `CHK("pins", 8'h23, {pin_out, pin_oe})
    `CHK("pwr", 1'b0, pin_in[0])
    wb(1'b0, 8'h04, 32'h0);
    `CHK("stat", 32'h00200e32, rd)
    us(6'b110001);
    `CHK("pins", 8'h02, {pin_out, pin_oe})
    `CHK("pwr", 1'b1, pin_in[0])
    wb(1'b1, 8'h00, 32'h10084);
    tk(3);
    `CHK("pins", 8'h22, {pin_out, pin_oe})
    $display("test power done");
  endtask : t_power

  // one-cycle activity strobe; count low cycles on each led pin
  task automatic t_led;
    int c [3];
    logic [3:0] od;
    us(6'b000000);
    wb(1'b1, 8'h00, 32'h0765);
    tk(3);
    for (int k = 0; k < 2; k++) begin
      c = '{0, 0, 0};
      od = 4'h0;
      @(posedge clock);
      usb <= (k == 0) ? 6'b000100 : 6'b000010;
      @(posedge clock);
      usb <= 6'b000000;
      repeat (24) begin
        tk(1);
        for (int p = 0; p < 3; p++) c[p] += pin_oe[p];
        od |= pin_out;
      end
      `CHK("tx", (k == 0) ? ON : 0, c[0])
      `CHK("rx", (k == 1) ? ON : 0, c[1])
      `CHK("both", ON, c[2])
      `CHK("od", 3'b000, od[2:0])
    end
    $display("test led done");
  endtask : t_led

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    usb = '0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_power();
    t_led();
    wrap_up();
  end
endmodule : tb

`default_nettype wire
